// ===== logic/efb_pkg.sv
// Package with offsets, field positions, reset values and timing counts of the error bank.
package efb_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CHECK_PERIOD_US = 1;
    localparam int unsigned CHECK_CYCLES = CHECK_PERIOD_US * CLK_MHZ;
    localparam logic [5:0] ADDR_ERROR_FLAGS = 6'h06;
    localparam logic [5:0] ADDR_ERROR_ENABLE = 6'h07;
    localparam logic [5:0] ADDR_CLOCK_COUNT = 6'h08;
    localparam logic [15:0] ENABLE_RESET = 16'h0040;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_WRITABLE = 16'h1FFF;
    localparam logic [15:0] FLAG_BITS = 16'h0FFF;
    localparam int unsigned BIT_ROM_CRC = 0;
    localparam int unsigned BIT_MAP_CRC = 1;
    localparam int unsigned BIT_LINK_CRC = 2;
    localparam int unsigned BIT_BAD_WRITE = 3;
    localparam int unsigned BIT_BAD_READ = 4;
    localparam int unsigned BIT_CLOCK_COUNT = 5;
    localparam int unsigned BIT_RANGE_FAULT = 11;
    localparam int unsigned BIT_COUNTER_EN = 12;
    localparam logic [7:0] CRC_SEED = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h07;
    typedef enum logic [1:0] {
        EFB_ROM_IDLE = 2'b00,
        EFB_ROM_WALK = 2'b01,
        EFB_ROM_DONE = 2'b10
    } efb_rom_state_t;
endpackage

// ===== logic/efb_crc8.sv
// Combinational CRC-8 step over one 16-bit word.
`timescale 1ns/1ps
module efb_crc8 #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic [7:0] crc_in,
    input wire logic [WIDTH-1:0] data,
    output logic [7:0] crc_out
);
    always_comb begin
        logic [7:0] c;
        c = crc_in;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (c[7] ^ data[i]) begin
                c = {c[6:0], 1'b0} ^ efb_pkg::CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule // efb_crc8

// ===== logic/efb_error_bank.sv
// Error flag register, error enable register and their checkers.
// How it works
// - Bad read address sets read flag.
// - Bad write address sets bit 3.
// - Frame checksum mismatch sets link flag.
// - Map checksum runs periodically when enabled; bit 1.
// - Map change without write sets map flag.
// - Power-up ROM checksum mismatch sets ROM flag.
// - Flags reset zero, gated, sticky, write-one-clear.
// - Enable register at 0x07, resets 0x0040.
// - Bit 12 runs master clock counter.
// - Bit 11 gates positive input range fault.
// - Enable bits 15 to 13 read zero.
// - Partial-byte frame sets clock count flag.
`timescale 1ns/1ps
module efb_error_bank #(
    parameter int unsigned ROM_DEPTH = 16,
    parameter int unsigned ROM_AW = 4,
    parameter logic [7:0] ROM_CRC_REF = 8'h00,
    parameter int unsigned COUNT_WIDTH = 16
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic FRAME_CRC_BAD,
    input wire logic FRAME_PARTIAL_BYTE,
    input wire logic RANGE_FAULT_PIN,
    output logic [ROM_AW-1:0] ROM_ADDR,
    input wire logic [15:0] ROM_DATA,
    output logic ROM_CHECK_DONE,
    output logic [15:0] ERROR_FLAGS,
    output logic COUNTER_RUN
);
    logic [15:0] enable_mask;
    logic [15:0] flags;
    logic [15:0] next_flags;
    logic [15:0] events;
    logic [COUNT_WIDTH-1:0] clock_count;
    logic addr_valid;
    logic fault_s1;
    logic fault_s2;
    logic fault_s3;
    logic fault_level;
    logic [7:0] map_ref;
    logic [7:0] map_crc;
    logic refresh_pending;
    localparam int unsigned CHECK_W = $clog2(efb_pkg::CHECK_CYCLES);
    logic [CHECK_W-1:0] check_timer;
    logic check_tick;
    logic map_mismatch;
    efb_pkg::efb_rom_state_t rom_state;
    logic [7:0] rom_acc;
    logic [7:0] rom_next_acc;
    logic rom_mismatch;

    assign addr_valid = (REG_ADDR == efb_pkg::ADDR_ERROR_FLAGS)
        || (REG_ADDR == efb_pkg::ADDR_ERROR_ENABLE)
        || (REG_ADDR == efb_pkg::ADDR_CLOCK_COUNT);

    // Enable register; reserved top bits never store a one.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            enable_mask <= efb_pkg::ENABLE_RESET;
        end else if (REG_WR && REG_ADDR == efb_pkg::ADDR_ERROR_ENABLE) begin
            enable_mask <= REG_WDATA & efb_pkg::ENABLE_WRITABLE;
        end
    end

    // The range pin is asynchronous, so it is filtered before use.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fault_s1 <= 1'b0;
            fault_s2 <= 1'b0;
            fault_s3 <= 1'b0;
            fault_level <= 1'b0;
        end else begin
            fault_s1 <= RANGE_FAULT_PIN;
            fault_s2 <= fault_s1;
            fault_s3 <= fault_s2;
            if (fault_s2 == fault_s3) begin
                fault_level <= fault_s3;
            end
        end
    end

    always_comb begin
        events = 16'h0000;
        events[efb_pkg::BIT_BAD_READ] = REG_RD && !addr_valid;
        events[efb_pkg::BIT_BAD_WRITE] = REG_WR && !addr_valid;
        events[efb_pkg::BIT_LINK_CRC] = FRAME_CRC_BAD;
        events[efb_pkg::BIT_CLOCK_COUNT] = FRAME_PARTIAL_BYTE;
        events[efb_pkg::BIT_MAP_CRC] = map_mismatch;
        events[efb_pkg::BIT_ROM_CRC] = rom_mismatch;
        events[efb_pkg::BIT_RANGE_FAULT] = fault_level;
    end

    // A set arriving with its clear wins, so no event is lost.
    always_comb begin
        next_flags = flags;
        if (REG_WR && REG_ADDR == efb_pkg::ADDR_ERROR_FLAGS) begin
            next_flags = next_flags & ~REG_WDATA;
        end
        next_flags = next_flags | (events & enable_mask & efb_pkg::FLAG_BITS);
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flags <= efb_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            clock_count <= '0;
        end else if (enable_mask[efb_pkg::BIT_COUNTER_EN]) begin
            clock_count <= clock_count + 1'b1;
        end
    end

    efb_crc8 #(
        .WIDTH(16)
    ) u_map_crc (
        .crc_in(efb_pkg::CRC_SEED),
        .data(enable_mask),
        .crc_out(map_crc)
    );

    // The reference follows one cycle after a write, once the mask has settled.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            refresh_pending <= 1'b1;
            map_ref <= 8'h00;
        end else begin
            refresh_pending <= REG_WR;
            if (refresh_pending) begin
                map_ref <= map_crc;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            check_timer <= '0;
            check_tick <= 1'b0;
        end else if (!enable_mask[efb_pkg::BIT_MAP_CRC]) begin
            check_timer <= '0;
            check_tick <= 1'b0;
        end else if (check_timer == CHECK_W'(efb_pkg::CHECK_CYCLES - 1)) begin
            check_timer <= '0;
            check_tick <= 1'b1;
        end else begin
            check_timer <= check_timer + 1'b1;
            check_tick <= 1'b0;
        end
    end

    // A pending refresh suppresses the compare so a fresh write never trips it.
    assign map_mismatch = check_tick && !refresh_pending && !REG_WR && (map_crc != map_ref);

    efb_crc8 #(
        .WIDTH(16)
    ) u_rom_crc (
        .crc_in(rom_acc),
        .data(ROM_DATA),
        .crc_out(rom_next_acc)
    );

    // ROM data arrive one cycle after the address, so the walk lags by one word.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rom_state <= efb_pkg::EFB_ROM_IDLE;
            ROM_ADDR <= '0;
            rom_acc <= efb_pkg::CRC_SEED;
            rom_mismatch <= 1'b0;
            ROM_CHECK_DONE <= 1'b0;
        end else begin
            rom_mismatch <= 1'b0;
            case (rom_state)
                efb_pkg::EFB_ROM_IDLE: begin
                    rom_state <= efb_pkg::EFB_ROM_WALK;
                    ROM_ADDR <= ROM_ADDR + 1'b1;
                end
                efb_pkg::EFB_ROM_WALK: begin
                    rom_acc <= rom_next_acc;
                    if (ROM_ADDR == '0) begin
                        rom_state <= efb_pkg::EFB_ROM_DONE;
                        rom_mismatch <= (rom_next_acc != ROM_CRC_REF);
                        ROM_CHECK_DONE <= 1'b1;
                    end else if (ROM_ADDR == ROM_AW'(ROM_DEPTH - 1)) begin
                        ROM_ADDR <= '0;
                    end else begin
                        ROM_ADDR <= ROM_ADDR + 1'b1;
                    end
                end
                efb_pkg::EFB_ROM_DONE: begin
                    rom_state <= efb_pkg::EFB_ROM_DONE;
                end
                default: begin
                    rom_state <= efb_pkg::EFB_ROM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                case (REG_ADDR)
                    efb_pkg::ADDR_ERROR_FLAGS: REG_RDATA <= flags;
                    efb_pkg::ADDR_ERROR_ENABLE: REG_RDATA <= enable_mask;
                    efb_pkg::ADDR_CLOCK_COUNT: REG_RDATA <= 16'(clock_count);
                    default: REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ERROR_FLAGS <= efb_pkg::FLAGS_RESET;
            COUNTER_RUN <= 1'b0;
        end else begin
            ERROR_FLAGS <= next_flags;
            COUNTER_RUN <= enable_mask[efb_pkg::BIT_COUNTER_EN];
        end
    end
endmodule // efb_error_bank

// ===== verif/efb_rom_model.sv
// Behavioural ROM answering the power-up checksum walk.
`timescale 1ns/1ps
module efb_rom_model (
    input wire logic clk,
    input wire logic [3:0] addr,
    output logic [15:0] data
);
    // Every word differs, so a skipped or repeated read changes the checksum.
    always_ff @(posedge clk) begin
        data <= {addr, ~addr, 8'h3C};
    end
endmodule // efb_rom_model

// ===== verif/efb_error_bank_assertions.sv
// Assertion checker for the error bank ports.
`timescale 1ns/1ps
module efb_chk #(
    parameter int unsigned ROM_AW = 4
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic FRAME_CRC_BAD,
    input wire logic FRAME_PARTIAL_BYTE,
    input wire logic RANGE_FAULT_PIN,
    input wire logic [ROM_AW-1:0] ROM_ADDR,
    input wire logic [15:0] ROM_DATA,
    input wire logic ROM_CHECK_DONE,
    input wire logic [15:0] ERROR_FLAGS,
    input wire logic COUNTER_RUN
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    AST_READ_VALID: assert property (REG_RD |=> REG_RVALID) else $error("no read answer");
    AST_RESERVED_ZERO: assert property (REG_RD && REG_ADDR == 6'h07 |=> REG_RDATA[15:13] == 3'h0)
        else $error("reserved enable bits set");
    AST_STICKY: assert property ((($past(ERROR_FLAGS) & ~ERROR_FLAGS) & ~(($past(REG_WR) &&
        $past(REG_ADDR) == 6'h06) ? $past(REG_WDATA) : 16'h0000)) == 16'h0000)
        else $error("flag lost");
    AST_LINK_CAUSE: assert property ($rose(ERROR_FLAGS[2]) |-> $past(FRAME_CRC_BAD))
        else $error("link flag without cause");
    AST_COUNT_CAUSE: assert property ($rose(ERROR_FLAGS[5]) |-> $past(FRAME_PARTIAL_BYTE))
        else $error("count flag without cause");
    AST_BAD_WRITE: assert property ($rose(ERROR_FLAGS[3]) |-> $past(REG_WR) &&
        !($past(REG_ADDR) inside {6'h06, 6'h07, 6'h08})) else $error("write flag without cause");
    AST_BAD_READ: assert property ($rose(ERROR_FLAGS[4]) |-> $past(REG_RD) &&
        !($past(REG_ADDR) inside {6'h06, 6'h07, 6'h08})) else $error("read flag without cause");
    // The mismatch pulse rises with done, so the flag shows one cycle after done.
    AST_ROM_FLAG: assert property ($rose(ERROR_FLAGS[0]) |-> ROM_CHECK_DONE &&
        !$past(ROM_CHECK_DONE, 2)) else $error("rom flag outside check");
    AST_ROM_DONE: assert property (ROM_CHECK_DONE |=> ROM_CHECK_DONE) else $error("done dropped");
    AST_COUNTER: assert property (REG_WR && REG_ADDR == 6'h07 |=> ##1
        COUNTER_RUN == (($past(REG_WDATA, 2) & 16'h1000) != 16'h0000))
        else $error("counter run");
endmodule // efb_chk
bind efb_error_bank efb_chk #(.ROM_AW(ROM_AW)) efb_chk_inst (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .FRAME_CRC_BAD(FRAME_CRC_BAD),
    .FRAME_PARTIAL_BYTE(FRAME_PARTIAL_BYTE), .RANGE_FAULT_PIN(RANGE_FAULT_PIN),
    .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA), .ROM_CHECK_DONE(ROM_CHECK_DONE),
    .ERROR_FLAGS(ERROR_FLAGS), .COUNTER_RUN(COUNTER_RUN));

// ===== verif/tb_top.sv
// Self-checking bench for the error bank.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
    typedef struct packed {logic [15:0] en; logic [3:0] act; logic [5:0] addr;
        logic [15:0] flags;} efb_row_t;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic FRAME_CRC_BAD = 1'b0;
    logic FRAME_PARTIAL_BYTE = 1'b0;
    logic RANGE_FAULT_PIN = 1'b0;
    logic [5:0] REG_ADDR = 6'h00;
    logic [15:0] REG_WDATA = 16'h0000;
    logic [15:0] REG_RDATA, ROM_DATA, ERROR_FLAGS;
    logic [3:0] ROM_ADDR;
    logic REG_RVALID, ROM_CHECK_DONE, COUNTER_RUN, seen;
    logic [7:0] rom_crc;
    logic [15:0] cnt_seen;
    int n_mismatch = 0;
    int comparisons = 0;
    // Act bits: checksum pulse, partial-byte pulse, write, read.
    efb_row_t rows [6] = '{'{16'h1FFF, 4'h8, 6'h00, 16'h0004}, '{16'h1FFF, 4'h4, 6'h00, 16'h0020},
        '{16'h1FFF, 4'h2, 6'h20, 16'h0008}, '{16'h1FFF, 4'h1, 6'h21, 16'h0010},
        '{16'h0000, 4'h8, 6'h00, 16'h0000}, '{16'h1FF7, 4'h2, 6'h20, 16'h0000}};
    always #4 REF_CLK = ~REF_CLK;
    efb_error_bank #(.ROM_DEPTH(16), .ROM_AW(4), .ROM_CRC_REF(8'h00), .COUNT_WIDTH(16))
        efb_error_bank_inst (.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .FRAME_CRC_BAD(FRAME_CRC_BAD),
        .FRAME_PARTIAL_BYTE(FRAME_PARTIAL_BYTE), .RANGE_FAULT_PIN(RANGE_FAULT_PIN),
        .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA), .ROM_CHECK_DONE(ROM_CHECK_DONE),
        .ERROR_FLAGS(ERROR_FLAGS), .COUNTER_RUN(COUNTER_RUN));
    efb_rom_model efb_rom_model_inst (.clk(REF_CLK), .addr(ROM_ADDR), .data(ROM_DATA));
    // Strobes are only driven here, once per falling edge, so no signal is assigned twice.
    task automatic access(input logic [3:0] act, input logic [5:0] addr, input logic [15:0] wdata);
        {FRAME_CRC_BAD, FRAME_PARTIAL_BYTE, REG_WR, REG_RD} = act;
        REG_ADDR = addr;
        REG_WDATA = wdata;
        @(negedge REF_CLK);
        seen = REG_RVALID;
    endtask
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        rom_crc = 8'hFF;
        for (int a = 0; a < 16; a++) begin
            rom_crc = crc_step(rom_crc, {4'(a), ~4'(a), 8'h3C});
        end
        repeat (8) @(negedge REF_CLK);
        RSTN = 1'b1;
        `CHK(ERROR_FLAGS, 16'h0000)
        access(4'h1, 6'h07, 16'h0000);
        `CHK(REG_RDATA, 16'h0040)
        access(4'h2, 6'h07, 16'hFFFF);
        access(4'h1, 6'h07, 16'h0000);
        `CHK({seen, COUNTER_RUN, REG_RDATA}, {2'b11, 16'h1FFF})
        $display("reset and enable test done");
        for (int i = 0; i < 40 && ROM_CHECK_DONE !== 1'b1; i++) access(4'h0, 6'h00, 16'h0000);
        if (ROM_CHECK_DONE !== 1'b1) begin
            n_mismatch++;
            final_report;
        end
        // The flag is set from the registered mismatch pulse, one cycle after done.
        access(4'h0, 6'h00, 16'h0000);
        `CHK({ROM_CHECK_DONE, ERROR_FLAGS[0]}, {1'b1, rom_crc != 8'h00})
        repeat (260) access(4'h0, 6'h00, 16'h0000);
        `CHK(ERROR_FLAGS[1], 1'b0)
        access(4'h2, 6'h06, 16'hFFFF);
        $display("power-up checks done");
        foreach (rows[r]) begin
            access(4'h2, 6'h07, rows[r].en);
            access(rows[r].act, rows[r].addr, 16'h0000);
            repeat (3) access(4'h0, 6'h00, 16'h0000);
            `CHK(ERROR_FLAGS, rows[r].flags)
            access(4'h2, 6'h06, 16'hFFFF);
            access(4'h0, 6'h00, 16'h0000);
            `CHK(ERROR_FLAGS, 16'h0000)
            $display("row %0d done", r);
        end
        access(4'h2, 6'h07, 16'h0000);
        RANGE_FAULT_PIN = 1'b1;
        repeat (8) access(4'h0, 6'h00, 16'h0000);
        `CHK({COUNTER_RUN, ERROR_FLAGS[11]}, 2'b00)
        access(4'h2, 6'h07, 16'h0800);
        repeat (8) access(4'h0, 6'h00, 16'h0000);
        `CHK(ERROR_FLAGS[11], 1'b1)
        $display("range test done");
        access(4'h1, 6'h08, 16'h0000);
        cnt_seen = REG_RDATA;
        repeat (3) access(4'h0, 6'h00, 16'h0000);
        access(4'h1, 6'h08, 16'h0000);
        `CHK(REG_RDATA, cnt_seen)
        access(4'h2, 6'h07, 16'h1000);
        access(4'h1, 6'h08, 16'h0000);
        cnt_seen = REG_RDATA;
        repeat (3) access(4'h0, 6'h00, 16'h0000);
        access(4'h1, 6'h08, 16'h0000);
        `CHK(REG_RDATA, cnt_seen + 16'h0004)
        $display("counter test done");
        RSTN = 1'b0;
        repeat (2) @(negedge REF_CLK);
        RSTN = 1'b1;
        `CHK(ERROR_FLAGS, 16'h0000)
        access(4'h1, 6'h07, 16'h0000);
        `CHK({seen, COUNTER_RUN, REG_RDATA}, {2'b10, 16'h0040})
        $display("mid-run reset test done");
        final_report;
    end
endmodule // tb_top
